//--- shared/spa_pkg.sv
package spa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses on the APB side)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BUF  = 8'h04;
  localparam logic [7:0] OFS_PWR  = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_MODE0_BIT = 7;
  localparam int PWR_DOUBLE_BIT = 7;
  localparam int PWR_FE_SEL_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic       PWR_RESET  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing counts in oscillator clocks, sample ticks and bits
  localparam logic [3:0] M0_FAST_CLKS = 4'h4;
  localparam logic [3:0] M0_SLOW_CLKS = 4'hc;
  localparam logic [3:0] M0_FAST_Q    = M0_FAST_CLKS >> 2;
  localparam logic [3:0] M0_SLOW_Q    = M0_SLOW_CLKS >> 2;
  localparam logic [3:0] OVS_LAST     = 4'hf;
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [3:0] M1_LAST_SMP  = 4'h8;
  localparam logic [3:0] M23_LAST_SMP = 4'h9;
  localparam logic [3:0] M1_LAST_BIT  = 4'h9;
  localparam logic [3:0] M23_LAST_BIT = 4'ha;
  localparam logic [3:0] M0_LAST_BIT  = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic mode_select_bit0;
    logic mode_select_bit1;
    logic multiproc_speed_bit;
    logic rx_enable;
    logic tx_bit9;
    logic rx_bit9;
    logic transmit_done_flag;
    logic receive_complete_flag;
  } spa_ctrl_t;

  typedef enum logic [1:0] {
    TX_IDLE     = 2'b00,
    TX_ASYNC    = 2'b01,
    TX_SYNC_OUT = 2'b10,
    TX_SYNC_IN  = 2'b11
  } spa_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } spa_rx_state_t;

endpackage

//--- logic/spa_addr_match.sv
`timescale 1ns/10ps
module spa_addr_match #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] byte_in,
  input  wire logic [WIDTH-1:0] addr_in,
  input  wire logic [WIDTH-1:0] mask_in,
  output logic                  hit_out
);

  logic [WIDTH-1:0] bcast;
  logic             given_hit;
  logic             bcast_hit;

  // Given address: only masked-in positions compared
  assign given_hit = ((byte_in ^ addr_in) & mask_in) == '0;

  // Broadcast: positions zero in both address and mask are don't-care
  assign bcast     = addr_in | mask_in;
  assign bcast_hit = ((byte_in ^ bcast) & bcast) == '0;

  assign hit_out   = given_hit | bcast_hit;

endmodule

//--- logic/spa_serial_port.sv
`timescale 1ns/10ps
module spa_serial_port (
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        baud_tick_in,
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe_out,
  output logic             txd_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  spa_pkg::spa_ctrl_t     ctrl_reg;
  spa_pkg::spa_tx_state_t tx_state_reg;
  spa_pkg::spa_rx_state_t rx_state_reg;

  logic        fe_reg;
  logic        fe_sel_reg;
  logic        double_reg;
  logic [7:0]  slave_address_reg_reg;
  logic [7:0]  smask_reg;
  logic [7:0]  rx_buf_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic        rxd_meta_reg;
  logic        rxd_sync_reg;
  logic        rxd_prev_reg;
  logic [1:0]  m2_div_reg;
  logic [10:0] tx_shift_reg;
  logic [3:0]  tx_bits_reg;
  logic [3:0]  tx_tick_reg;
  logic [3:0]  m0_phase_reg;
  logic        txd_reg;
  logic        rxd_drive_reg;
  logic        rxd_oe_reg;
  logic        tx_done_reg;
  logic        m0_rx_done_reg;
  logic [9:0]  rx_shift_reg;
  logic [3:0]  rx_bits_reg;
  logic [3:0]  rx_tick_reg;
  logic        rx_done_reg;

  logic        setup;
  logic        access;
  logic        hit_ctrl;
  logic        hit_buf;
  logic        hit_pwr;
  logic        hit_addr;
  logic        hit_mask;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_buf;
  logic        wr_pwr;
  logic [1:0]  mode;
  logic        is_m0;
  logic        is_m1;
  logic        sm2;
  logic        m2_tick;
  logic        baud16;
  logic [3:0]  m0_q;
  logic [3:0]  m0_last;
  logic        is_sync;
  logic [7:0]  async_byte;
  logic        async_stop;
  logic        async_ninth;
  logic        addr_hit;
  logic        accept;
  logic        ri_set;
  logic        fe_set;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup    = psel_in & ~penable_in;
  assign access   = psel_in & penable_in;
  assign hit_ctrl = paddr_in == spa_pkg::OFS_CTRL;
  assign hit_buf  = paddr_in == spa_pkg::OFS_BUF;
  assign hit_pwr  = paddr_in == spa_pkg::OFS_PWR;
  assign hit_addr = paddr_in == spa_pkg::OFS_ADDR;
  assign hit_mask = paddr_in == spa_pkg::OFS_MASK;
  assign mapped   = hit_ctrl | hit_buf | hit_pwr | hit_addr | hit_mask;
  assign wr_ctrl  = access & pwrite_in & hit_ctrl;
  assign wr_buf   = access & pwrite_in & hit_buf;
  assign wr_pwr   = access & pwrite_in & hit_pwr;

  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~mapped;
  assign prdata_out  = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Mode and rate selection
  assign mode    = {ctrl_reg.mode_select_bit1, ctrl_reg.mode_select_bit0};
  assign is_m0   = mode == 2'b00;
  assign is_m1   = mode == 2'b01;
  assign sm2     = ctrl_reg.multiproc_speed_bit;
  // Mode 2: 16 samples per bit, one every 2 or 4 clocks
  assign m2_tick = double_reg ? m2_div_reg[0] : &m2_div_reg;
  assign baud16  = (mode == 2'b10) ? m2_tick : baud_tick_in;
  assign m0_q    = sm2 ? spa_pkg::M0_FAST_Q : spa_pkg::M0_SLOW_Q;
  assign m0_last = sm2 ? (spa_pkg::M0_FAST_CLKS - 4'h1) : (spa_pkg::M0_SLOW_CLKS - 4'h1);
  assign is_sync = tx_state_reg[1];

  assign txd_out    = txd_reg;
  assign rxd_out    = rxd_drive_reg;
  assign rxd_oe_out = rxd_oe_reg;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      m2_div_reg <= 2'h0;
    end else begin
      m2_div_reg <= m2_div_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data pin synchroniser and edge memory
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd_in;
      rxd_sync_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter and mode 0 shift engine
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state_reg   <= spa_pkg::TX_IDLE;
      tx_shift_reg   <= 11'h7ff;
      tx_bits_reg    <= 4'h0;
      tx_tick_reg    <= 4'h0;
      m0_phase_reg   <= 4'h0;
      txd_reg        <= 1'b1;
      rxd_drive_reg  <= 1'b1;
      rxd_oe_reg     <= 1'b0;
      tx_done_reg    <= 1'b0;
      m0_rx_done_reg <= 1'b0;
    end else begin
      tx_done_reg    <= 1'b0;
      m0_rx_done_reg <= 1'b0;
      case (tx_state_reg)
        spa_pkg::TX_IDLE: begin
          txd_reg    <= 1'b1;
          rxd_oe_reg <= 1'b0;
          if (wr_buf && is_m0) begin
            tx_state_reg  <= spa_pkg::TX_SYNC_OUT;
            tx_shift_reg  <= {3'h7, pwdata_in[7:0]};
            rxd_drive_reg <= pwdata_in[0];
            rxd_oe_reg    <= 1'b1;
            m0_phase_reg  <= 4'h0;
            tx_bits_reg   <= 4'h0;
          end else if (wr_buf) begin
            tx_state_reg <= spa_pkg::TX_ASYNC;
            // Mode 1 puts its one stop bit where the ninth would sit
            tx_shift_reg <= {1'b1, is_m1 | ctrl_reg.tx_bit9, pwdata_in[7:0], 1'b0};
            tx_bits_reg  <= is_m1 ? spa_pkg::M1_LAST_BIT : spa_pkg::M23_LAST_BIT;
            tx_tick_reg  <= 4'h0;
          end else if (is_m0 && ctrl_reg.rx_enable && !ctrl_reg.receive_complete_flag &&
                       !m0_rx_done_reg) begin
            tx_state_reg <= spa_pkg::TX_SYNC_IN;
            m0_phase_reg <= 4'h0;
            tx_bits_reg  <= 4'h0;
          end
        end
        spa_pkg::TX_ASYNC: begin
          txd_reg <= tx_shift_reg[0];
          if (baud16) begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == spa_pkg::OVS_LAST) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
              if (tx_bits_reg == 4'h0) begin
                tx_state_reg <= spa_pkg::TX_IDLE;
                tx_done_reg  <= 1'b1;
              end else begin
                tx_bits_reg <= tx_bits_reg - 4'h1;
              end
            end
          end
        end
        default: begin
          // Clock low from phase q to 3q-1, high otherwise
          txd_reg <= ~((m0_phase_reg >= m0_q - 4'h1) &&
                       (m0_phase_reg < (m0_q * 4'h3) - 4'h1));
          if (tx_state_reg == spa_pkg::TX_SYNC_IN && m0_phase_reg == m0_q * 4'h3) begin
            tx_shift_reg[7:0] <= {rxd_sync_reg, tx_shift_reg[7:1]};
          end
          if (m0_phase_reg == m0_last) begin
            m0_phase_reg <= 4'h0;
            tx_bits_reg  <= tx_bits_reg + 4'h1;
            if (tx_state_reg == spa_pkg::TX_SYNC_OUT) begin
              rxd_drive_reg <= tx_shift_reg[1];
              tx_shift_reg  <= {1'b1, tx_shift_reg[10:1]};
            end
            if (tx_bits_reg == spa_pkg::M0_LAST_BIT) begin
              tx_state_reg   <= spa_pkg::TX_IDLE;
              rxd_oe_reg     <= 1'b0;
              rxd_drive_reg  <= 1'b1;
              tx_done_reg    <= tx_state_reg == spa_pkg::TX_SYNC_OUT;
              m0_rx_done_reg <= tx_state_reg == spa_pkg::TX_SYNC_IN;
            end
          end else begin
            m0_phase_reg <= m0_phase_reg + 4'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous receiver, 16 samples per bit
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_state_reg <= spa_pkg::RX_IDLE;
      rx_shift_reg <= 10'h000;
      rx_bits_reg  <= 4'h0;
      rx_tick_reg  <= 4'h0;
      rx_done_reg  <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      case (rx_state_reg)
        spa_pkg::RX_IDLE: begin
          if (!is_m0 && ctrl_reg.rx_enable && rxd_prev_reg && !rxd_sync_reg) begin
            rx_state_reg <= spa_pkg::RX_START;
            rx_tick_reg  <= 4'h0;
          end
        end
        spa_pkg::RX_START: begin
          if (baud16) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == spa_pkg::SAMPLE_POINT) begin
              // A start bit that is high at its centre was a glitch
              if (rxd_sync_reg) begin
                rx_state_reg <= spa_pkg::RX_IDLE;
              end else begin
                rx_state_reg <= spa_pkg::RX_DATA;
                rx_bits_reg  <= 4'h0;
              end
            end
          end
        end
        default: begin
          if (baud16) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == spa_pkg::SAMPLE_POINT) begin
              rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[9:1]};
              rx_bits_reg  <= rx_bits_reg + 4'h1;
              if (rx_bits_reg == (is_m1 ? spa_pkg::M1_LAST_SMP : spa_pkg::M23_LAST_SMP)) begin
                rx_state_reg <= spa_pkg::RX_IDLE;
                rx_done_reg  <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame acceptance and address recognition
  assign async_byte  = is_m1 ? rx_shift_reg[8:1] : rx_shift_reg[7:0];
  assign async_stop  = rx_shift_reg[9];
  assign async_ninth = is_m1 ? async_stop : rx_shift_reg[8];

  spa_addr_match #(
    .WIDTH (8)
  ) u_match (
    .byte_in (async_byte),
    .addr_in (slave_address_reg_reg),
    .mask_in (smask_reg),
    .hit_out (addr_hit)
  );

  // With the multiprocessor bit set only an address frame that matches passes
  assign accept = rx_done_reg && !ctrl_reg.receive_complete_flag &&
                  (!sm2 || (async_ninth && addr_hit));
  assign ri_set = accept | m0_rx_done_reg;
  assign fe_set = rx_done_reg & ~async_stop;

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_buf_reg <= 8'h00;
    end else if (m0_rx_done_reg) begin
      rx_buf_reg <= tx_shift_reg[7:0];
    end else if (accept) begin
      rx_buf_reg <= async_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; hardware sets win over software writes
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg <= spa_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        if (!fe_sel_reg) begin
          ctrl_reg.mode_select_bit0 <= pwdata_in[spa_pkg::CTRL_MODE0_BIT];
        end
        ctrl_reg.mode_select_bit1    <= pwdata_in[6];
        ctrl_reg.multiproc_speed_bit <= pwdata_in[5];
        ctrl_reg.rx_enable           <= pwdata_in[4];
        ctrl_reg.tx_bit9             <= pwdata_in[3];
      end
      if (accept) begin
        ctrl_reg.rx_bit9 <= async_ninth;
      end else if (wr_ctrl) begin
        ctrl_reg.rx_bit9 <= pwdata_in[2];
      end
      ctrl_reg.transmit_done_flag <= tx_done_reg |
        (wr_ctrl ? pwdata_in[1] : ctrl_reg.transmit_done_flag);
      ctrl_reg.receive_complete_flag <= ri_set |
        (wr_ctrl ? pwdata_in[0] : ctrl_reg.receive_complete_flag);
    end
  end

  // Error flag: set by hardware, software may only write it to zero
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fe_reg <= 1'b0;
    end else if (fe_set) begin
      fe_reg <= 1'b1;
    end else if (wr_ctrl && fe_sel_reg && !pwdata_in[spa_pkg::CTRL_MODE0_BIT]) begin
      fe_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power control and address registers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fe_sel_reg <= spa_pkg::PWR_RESET;
      double_reg <= spa_pkg::PWR_RESET;
    end else if (wr_pwr) begin
      fe_sel_reg <= pwdata_in[spa_pkg::PWR_FE_SEL_BIT];
      double_reg <= pwdata_in[spa_pkg::PWR_DOUBLE_BIT];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      slave_address_reg_reg <= spa_pkg::ADDR_RESET;
      smask_reg <= spa_pkg::MASK_RESET;
    end else if (access && pwrite_in) begin
      if (hit_addr) begin
        slave_address_reg_reg <= pwdata_in[7:0];
      end
      if (hit_mask) begin
        smask_reg <= pwdata_in[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, captured in the setup cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[7:0] = ctrl_reg;
      rd_mux[spa_pkg::CTRL_MODE0_BIT] = fe_sel_reg ? fe_reg : ctrl_reg.mode_select_bit0;
    end else if (hit_buf) begin
      rd_mux[7:0] = rx_buf_reg;
    end else if (hit_pwr) begin
      rd_mux[spa_pkg::PWR_FE_SEL_BIT] = fe_sel_reg;
      rd_mux[spa_pkg::PWR_DOUBLE_BIT] = double_reg;
    end else if (hit_addr) begin
      rd_mux[7:0] = slave_address_reg_reg;
    end else if (hit_mask) begin
      rd_mux[7:0] = smask_reg;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite_in) begin
      prdata_reg <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  sequence s_low_fast;
    (!txd_out) [*2] ##1 txd_out;
  endsequence

  sequence s_low_slow;
    (!txd_out) [*6] ##1 txd_out;
  endsequence

  a_m0_fast_low: assert property (
    $fell(txd_out) && is_sync && sm2 |-> s_low_fast)
    else $error("fast shift clock low time wrong");

  a_m0_slow_low: assert property (
    $fell(txd_out) && is_sync && !sm2 |-> s_low_slow)
    else $error("slow shift clock low time wrong");

  a_buf_write_go: assert property (
    wr_buf && is_m0 && tx_state_reg == spa_pkg::TX_IDLE
    |=> tx_state_reg == spa_pkg::TX_SYNC_OUT && rxd_oe_out)
    else $error("buffer write did not start mode 0 shift");

  a_buf_read_rx: assert property (
    access && !pwrite_in && hit_buf |-> prdata_out == {24'h000000, $past(rx_buf_reg)})
    else $error("buffer read not from receive buffer");

  a_fe_raise: assert property (
    rx_done_reg && !rx_shift_reg[9] |=> fe_reg)
    else $error("missing stop bit did not set error flag");

  a_fe_sticky: assert property (
    fe_reg && !(wr_ctrl && fe_sel_reg && !pwdata_in[7]) |=> fe_reg)
    else $error("error flag cleared without software");

  a_ri_every: assert property (
    rx_done_reg && !sm2 && !ctrl_reg.receive_complete_flag |=> ctrl_reg.receive_complete_flag)
    else $error("frame did not set receive flag");

  a_ri_filter: assert property (
    rx_done_reg && sm2 && !addr_hit && !ctrl_reg.receive_complete_flag && !wr_ctrl
    |=> !ctrl_reg.receive_complete_flag)
    else $error("unmatched frame set receive flag");

  a_bit7_alias: assert property (
    setup && !pwrite_in && hit_ctrl && fe_sel_reg && !fe_set |=> prdata_out[7] == fe_reg)
    else $error("bit 7 did not show error flag");

endmodule

//--- dv/spa_far_end.sv
`timescale 1ns/10ps
module spa_far_end #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clock_in,
  input  wire logic data_in,
  input  wire logic data_oe_in,
  input  wire logic shift_clk_in,
  output logic      line_out,
  output logic      sdo_out
);
  logic [7:0] cap_reg;
  logic [7:0] low_reg;
  logic [7:0] low_max_reg;
  logic [7:0] lead_reg;
  logic       fell_reg;
  logic       oe_q_reg;
  initial line_out = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // Shift register device: takes the pin while driven, else rotates its byte out, LSB first
  always @(posedge shift_clk_in) begin
    cap_reg <= {data_oe_in ? data_in : cap_reg[0], cap_reg[7:1]};
  end
  assign sdo_out = cap_reg[0];
  // Measures clock-low width and data lead before the first falling shift clock
  always @(posedge clock_in) begin
    oe_q_reg <= data_oe_in;
    low_reg  <= (data_oe_in && !shift_clk_in) ? low_reg + 8'h01 : 8'h00;
    if (low_reg != 8'h00 && shift_clk_in) low_max_reg <= low_reg;
    fell_reg <= data_oe_in && (fell_reg || !shift_clk_in);
    if (data_oe_in && shift_clk_in && !fell_reg) lead_reg <= oe_q_reg ? lead_reg + 8'h01 : 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Async sender; the line is driven high when idle and after each frame
  task automatic send(input logic [7:0] d, input logic use9, input logic nine, input logic stop);
    logic [10:0] f;
    f = use9 ? {stop, nine, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < 12; i++) begin
      line_out <= (i < 11) ? f[i] : 1'b1;
      repeat (BIT_CLKS) @(posedge clock_in);
    end
  endtask
  // Async receiver: waits for the start edge, then samples each bit at its centre
  task automatic catch_frame(input int n, output logic [10:0] f);
    f = 11'h7ff;
    @(negedge shift_clk_in);
    repeat (BIT_CLKS / 2) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      f[i] = shift_clk_in;
      repeat (BIT_CLKS) @(posedge clock_in);
    end
  endtask
endmodule

//--- dv/spa_serial_port_tb_top.sv
`timescale 1ns/10ps
module spa_serial_port_tb_top;
  logic        clock_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        tick = 1'b0;
  logic        use9 = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  ctrl_val;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready, pslverr, err, rxd_out, rxd_oe, txd, line, pin, sdo;
  logic        m0rx = 1'b0;
  logic [10:0] fr;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  assign pin = rxd_oe ? rxd_out : (m0rx ? sdo : line);
  spa_serial_port u_dut (.clock_in(clock_in), .resetn_in(resetn_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .baud_tick_in(tick),
    .rxd_in(pin), .rxd_out(rxd_out), .rxd_oe_out(rxd_oe), .txd_out(txd));
  spa_far_end u_far (.clock_in(clock_in), .data_in(pin), .data_oe_in(rxd_oe),
    .shift_clk_in(txd), .line_out(line), .sdo_out(sdo));
  initial forever #50 clock_in = ~clock_in;
  // Timer stand-in: one tick every other clock, 32 clocks per bit
  always @(posedge clock_in) begin
    tick <= ~tick;
    cyc  <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rx_case(input logic [7:0] d, input logic nine, input logic stop, input logic e);
    u_far.send(d, use9, nine, stop);
    apb(1'b0, spa_pkg::OFS_CTRL, 8'h00);
    chk({7'h0, q[0]}, {7'h0, e});
    if (e) begin
      apb(1'b0, spa_pkg::OFS_BUF, 8'h00);
      chk(q[7:0], d);
    end
    apb(1'b1, spa_pkg::OFS_CTRL, ctrl_val);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    apb(1'b0, spa_pkg::OFS_CTRL, 8'h00);
    chk(q[7:0], spa_pkg::CTRL_RESET);
    apb(1'b0, spa_pkg::OFS_MASK, 8'h00);
    chk(q[7:0], spa_pkg::MASK_RESET);
    apb(1'b0, 8'h20, 8'h00);
    chk({7'h0, err}, 8'h01);
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, spa_pkg::OFS_CTRL, s ? 8'h20 : 8'h00);
      apb(1'b1, spa_pkg::OFS_BUF, 8'ha5 ^ s[7:0]);
      q = 32'h0;
      while (q[1] !== 1'b1) apb(1'b0, spa_pkg::OFS_CTRL, 8'h00);
      chk(u_far.cap_reg, 8'ha5 ^ s[7:0]);
      chk(u_far.low_max_reg, s ? 8'h02 : 8'h06);
      chk(u_far.lead_reg, s ? 8'h01 : 8'h03);
    end
    // Mode 0 receive: the far device shifts back the byte it last took in
    m0rx <= 1'b1;
    apb(1'b1, spa_pkg::OFS_CTRL, 8'h30);
    q = 32'h0;
    while (q[0] !== 1'b1) apb(1'b0, spa_pkg::OFS_CTRL, 8'h00);
    apb(1'b0, spa_pkg::OFS_BUF, 8'h00);
    chk(q[7:0], 8'ha5);
    apb(1'b1, spa_pkg::OFS_CTRL, 8'h00);
    m0rx <= 1'b0;
    apb(1'b1, spa_pkg::OFS_PWR, 8'h80);
    for (int m = 0; m < 3; m++) begin
      ctrl_val = (m == 0) ? 8'h90 : (m == 1) ? 8'h50 : 8'hd8;
      use9 = (m != 0);
      apb(1'b1, spa_pkg::OFS_CTRL, ctrl_val);
      rx_case(8'h5a + m[7:0], 1'b1, 1'b1, 1'b1);
      fork
        u_far.catch_frame(10 + use9, fr);
        apb(1'b1, spa_pkg::OFS_BUF, 8'hc3 ^ m[7:0]);
      join
      chk(fr[8:1], 8'hc3 ^ m[7:0]);
      chk({5'h0, fr[10:9], fr[0]}, {6'h01, ctrl_val[3] | !use9, 1'b0});
    end
    ctrl_val = 8'h50;
    apb(1'b1, spa_pkg::OFS_CTRL, ctrl_val);
    u_far.send(8'h33, 1'b1, 1'b0, 1'b0);
    apb(1'b1, spa_pkg::OFS_PWR, 8'hc0);
    ctrl_val = 8'hd0;
    apb(1'b1, spa_pkg::OFS_CTRL, ctrl_val);
    rx_case(8'h44, 1'b0, 1'b1, 1'b1);
    apb(1'b0, spa_pkg::OFS_CTRL, 8'h00);
    chk({7'h0, q[7]}, 8'h01);
    apb(1'b1, spa_pkg::OFS_CTRL, 8'h50);
    apb(1'b0, spa_pkg::OFS_CTRL, 8'h00);
    chk({7'h0, q[7]}, 8'h00);
    apb(1'b1, spa_pkg::OFS_PWR, 8'h80);
    apb(1'b0, spa_pkg::OFS_CTRL, 8'h00);
    chk(q[7:0], 8'h50);
    apb(1'b1, spa_pkg::OFS_ADDR, 8'h12);
    apb(1'b1, spa_pkg::OFS_MASK, 8'hf0);
    ctrl_val = 8'hf0;
    apb(1'b1, spa_pkg::OFS_CTRL, ctrl_val);
    ctrl_val = 8'hd0;
    rx_case(8'h13, 1'b1, 1'b1, 1'b1);
    ctrl_val = 8'hf0;
    rx_case(8'h77, 1'b0, 1'b1, 1'b1);
    rx_case(8'h13, 1'b0, 1'b1, 1'b0);
    rx_case(8'h25, 1'b1, 1'b1, 1'b0);
    rx_case(8'hf2, 1'b1, 1'b1, 1'b1);
    ctrl_val = 8'hb0;
    use9 = 1'b0;
    apb(1'b1, spa_pkg::OFS_CTRL, ctrl_val);
    rx_case(8'h1c, 1'b0, 1'b1, 1'b1);
    rx_case(8'h1c, 1'b0, 1'b0, 1'b0);
    complete_run();
  end
endmodule
